// ### shared/dbc_params.svh
`ifndef DBC_PARAMS_SVH
`define DBC_PARAMS_SVH

`define DBC_IR_EXTEST   3'h0
`define DBC_IR_SAMPLE   3'h1
`define DBC_IR_DEBUG    3'h2
`define DBC_IR_BYPASS   3'h3
`define DBC_IR_PROG     3'h4
`define DBC_IR_RSVD     3'h6
`define DBC_IR_CAPTURE  3'h1

`define DBC_CMD_NOP     8'h00
`define DBC_CMD_RD_CTRL 8'h01
`define DBC_CMD_RD_FLAG 8'h02
`define DBC_CMD_RD_ADDR 8'h03
`define DBC_CMD_RD_LAST 8'h0a
`define DBC_CMD_WR_CTRL 8'h11
`define DBC_CMD_WR_ADDR 8'h13
`define DBC_CMD_WR_LAST 8'h1a
`define DBC_CMD_DEBUG   8'h1f
`define DBC_CMD_WR_BIT  4

`define DBC_IDX_CTRL    4'h1
`define DBC_IDX_FLAG    4'h2
`define DBC_IDX_ADDR    4'h3
`define DBC_IDX_DATA    4'h4
`define DBC_IDX_BRK0    5
`define DBC_BP_NUM      6

`define DBC_BP_RESET    16'hffff
`define DBC_REG_RESET   16'h0000
`define DBC_CTRL_RESET  8'h00
`define DBC_STAT_BG     2'h0
`define DBC_STAT_DBG    2'h1
`define DBC_SRC_ISP     2'h0
`define DBC_FLAG_BP     0

`endif

// ### shared/dbc_pkg.sv
`include "dbc_params.svh"

package dbc_pkg;

	typedef enum logic [3:0] {
		st_tlr    = 4'h0,
		st_rti    = 4'h1,
		st_sel_dr = 4'h2,
		st_cap_dr = 4'h3,
		st_sh_dr  = 4'h4,
		st_ex1_dr = 4'h5,
		st_pa_dr  = 4'h6,
		st_ex2_dr = 4'h7,
		st_upd_dr = 4'h8,
		st_sel_ir = 4'h9,
		st_cap_ir = 4'ha,
		st_sh_ir  = 4'hb,
		st_ex1_ir = 4'hc,
		st_pa_ir  = 4'hd,
		st_ex2_ir = 4'he,
		st_upd_ir = 4'hf
	} dbc_tap_t;

	typedef enum logic [1:0] {
		path_bypass = 2'h0,
		path_debug  = 2'h1,
		path_prog   = 2'h2
	} dbc_path_t;

	typedef enum logic [1:0] {
		eng_cmd   = 2'h0,
		eng_read  = 2'h1,
		eng_write = 2'h2
	} dbc_eng_t;

	typedef struct packed {
		logic [1:0] status;
		logic [7:0] data;
	} dbc_word_t;

	typedef logic [`DBC_BP_NUM-1:0][15:0] dbc_bp_t;

	typedef struct packed {
		dbc_tap_t state;
	} dbc_fsm_t;

	typedef struct packed {
		logic      rst_s1;
		logic      rst_s2;
		logic [2:0] ir_shift;
		dbc_word_t dr_shift;
		logic [2:0] prog_shift;
		logic      bypass;
		logic      tog_s1;
		logic      tog_s2;
		logic      tog_seen;
		dbc_word_t tx_copy;
	} dbc_pos_t;

	typedef struct packed {
		logic [2:0] ir;
		dbc_path_t path;
		dbc_word_t reload;
		logic [7:0] rx_byte;
		logic      rx_tog;
		logic      tdo;
		logic      tdo_oe_n;
	} dbc_neg_t;

	typedef struct packed {
		logic      rx_s1;
		logic      rx_s2;
		logic      rx_seen;
		dbc_eng_t  eng;
		logic [1:0] cnt;
		logic [3:0] target;
		logic [7:0] hold;
		logic [7:0] buffer;
		dbc_word_t tx_word;
		logic      tx_tog;
		logic [7:0] ctrl;
		logic [7:0] flag;
		logic [15:0] addr;
		logic [15:0] data;
		dbc_bp_t   bp;
		logic      debug_req;
		logic      debug_mode;
		logic      halt;
		logic [7:0] fwd_byte;
		logic      fwd_valid;
	} dbc_core_t;

endpackage : dbc_pkg

// ### logic/dbc_tap_fsm.sv
`timescale 1ns/10ps

module dbc_tap_fsm (
	input  wire logic              i_tck,
	input  wire logic              i_tck_rstn,
	input  wire logic              i_tms,
	output dbc_pkg::dbc_tap_t      o_state
);

	dbc_pkg::dbc_fsm_t fsm;
	dbc_pkg::dbc_fsm_t next_fsm;

	always_comb begin
		next_fsm = fsm;
		case (fsm.state)
			dbc_pkg::st_tlr:    next_fsm.state = i_tms ? dbc_pkg::st_tlr : dbc_pkg::st_rti;
			dbc_pkg::st_rti:    next_fsm.state = i_tms ? dbc_pkg::st_sel_dr : dbc_pkg::st_rti;
			dbc_pkg::st_sel_dr: next_fsm.state = i_tms ? dbc_pkg::st_sel_ir : dbc_pkg::st_cap_dr;
			dbc_pkg::st_cap_dr: next_fsm.state = i_tms ? dbc_pkg::st_ex1_dr : dbc_pkg::st_sh_dr;
			dbc_pkg::st_sh_dr:  next_fsm.state = i_tms ? dbc_pkg::st_ex1_dr : dbc_pkg::st_sh_dr;
			dbc_pkg::st_ex1_dr: next_fsm.state = i_tms ? dbc_pkg::st_upd_dr : dbc_pkg::st_pa_dr;
			dbc_pkg::st_pa_dr:  next_fsm.state = i_tms ? dbc_pkg::st_ex2_dr : dbc_pkg::st_pa_dr;
			dbc_pkg::st_ex2_dr: next_fsm.state = i_tms ? dbc_pkg::st_upd_dr : dbc_pkg::st_sh_dr;
			dbc_pkg::st_upd_dr: next_fsm.state = i_tms ? dbc_pkg::st_sel_dr : dbc_pkg::st_rti;
			dbc_pkg::st_sel_ir: next_fsm.state = i_tms ? dbc_pkg::st_tlr : dbc_pkg::st_cap_ir;
			dbc_pkg::st_cap_ir: next_fsm.state = i_tms ? dbc_pkg::st_ex1_ir : dbc_pkg::st_sh_ir;
			dbc_pkg::st_sh_ir:  next_fsm.state = i_tms ? dbc_pkg::st_ex1_ir : dbc_pkg::st_sh_ir;
			dbc_pkg::st_ex1_ir: next_fsm.state = i_tms ? dbc_pkg::st_upd_ir : dbc_pkg::st_pa_ir;
			dbc_pkg::st_pa_ir:  next_fsm.state = i_tms ? dbc_pkg::st_ex2_ir : dbc_pkg::st_pa_ir;
			dbc_pkg::st_ex2_ir: next_fsm.state = i_tms ? dbc_pkg::st_upd_ir : dbc_pkg::st_sh_ir;
			dbc_pkg::st_upd_ir: next_fsm.state = i_tms ? dbc_pkg::st_sel_dr : dbc_pkg::st_rti;
			default:            next_fsm.state = dbc_pkg::st_tlr;
		endcase
		if (!i_tck_rstn) begin
			next_fsm.state = dbc_pkg::st_tlr;
		end
	end

	always_ff @(posedge i_tck) begin
		fsm <= next_fsm;
	end

	assign o_state = fsm.state;

endmodule : dbc_tap_fsm

// ### logic/dbc_debug_channel.sv
`timescale 1ns/10ps
`include "dbc_params.svh"

// Summary of operation
// - After Update-IR with debug instruction, a 10-bit shift path joins TDI and TDO.
// - Debug path stays until Test-Logic-Reset or an IR load other than EXTEST, SAMPLE or reserved 6h.
// - Every exchange is ten bits: two status bits and one byte.
// - Words shift least significant bit first.
// - The byte field talks to one holding buffer for both directions.
// - Update-DR falling edge loads the outgoing word from the holding buffer.
// - Same falling edge latches the incoming byte; the core copies it into the holding buffer after a two-flop crossing.
// - Background commands run without stalling or disturbing the CPU.
// - Enabled in-system programming takes the channel ahead of background traffic.
// - Status bits read 00b in background mode.
// - Commands read and write breakpoint, control, address and data registers, and read the flag register.
// - Host can see through commands that a breakpoint matched.
// - A command takes the engine from background into debug mode.
// - Debug mode halts the CPU and forwards received bytes on o_rx_byte instead of running them as commands.
// - Unsupported command bytes act as no-operation.
// - Engine watches and exposes its registers while user code keeps running.
// - Byte 00h is no-operation and the default shift register content.
// - Sixteen-bit reads take two follow-on transfers, low byte first.
// - Writes copy the holding buffer into the target when transfers end.
// - Command 1Fh forces debug mode and halts after the current instruction.
////////////////////////////////////////////////////////////////////////////////

module dbc_debug_channel (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rstn,
	input  wire logic              i_tck,
	input  wire logic              i_tms,
	input  wire logic              i_tdi,
	output logic                   o_tdo,
	output logic                   o_tdo_oe_n,
	input  wire logic              i_program_enable_bit,
	input  wire logic [1:0]        i_program_source_select,
	input  wire logic              i_bp_match,
	input  wire logic              i_instr_done,
	input  wire logic              i_debug_exit,
	output logic                   o_debug_mode,
	output logic                   o_cpu_halt,
	output logic [7:0]             o_debug_control_reg,
	output logic [7:0]             o_debug_flag_reg,
	output logic [15:0]            o_debug_address_reg,
	output logic [15:0]            o_debug_data_reg,
	output dbc_pkg::dbc_bp_t       o_breakpoint_regs,
	output logic [7:0]             o_debug_holding_buffer,
	output logic [7:0]             o_rx_byte,
	output logic                   o_rx_valid
);

	dbc_pkg::dbc_tap_t  tap_state;
	dbc_pkg::dbc_pos_t  pos;
	dbc_pkg::dbc_pos_t  next_pos;
	dbc_pkg::dbc_neg_t  neg;
	dbc_pkg::dbc_neg_t  next_neg;
	dbc_pkg::dbc_core_t core;
	dbc_pkg::dbc_core_t next_core;
	logic               rx_evt;
	logic               isp_on;
	logic               bg_cmd;
	logic [7:0]         rx_byte;
	logic [1:0]         cmd_len;
	logic [15:0]        rd_word;
	logic [15:0]        wr_word;

	function automatic logic [1:0] dbc_len(input logic [7:0] c);
		logic [1:0] n;
		n = 2'h0;
		if (c == `DBC_CMD_RD_CTRL || c == `DBC_CMD_RD_FLAG ||
				c == `DBC_CMD_WR_CTRL) begin
			n = 2'h1;
		end else if ((c >= `DBC_CMD_RD_ADDR && c <= `DBC_CMD_RD_LAST) ||
				(c >= `DBC_CMD_WR_ADDR && c <= `DBC_CMD_WR_LAST)) begin
			n = 2'h2;
		end
		return n;
	endfunction : dbc_len

	function automatic logic [15:0] dbc_rd(input dbc_pkg::dbc_core_t c,
			input logic [3:0] idx);
		logic [15:0] v;
		v = 16'h0000;
		case (idx)
			`DBC_IDX_CTRL: v = {8'h00, c.ctrl};
			`DBC_IDX_FLAG: v = {8'h00, c.flag};
			`DBC_IDX_ADDR: v = c.addr;
			`DBC_IDX_DATA: v = c.data;
			default: ;
		endcase
		for (int i = 0; i < `DBC_BP_NUM; i++) begin
			if (idx == 4'(i + `DBC_IDX_BRK0)) begin
				v = c.bp[i];
			end
		end
		return v;
	endfunction : dbc_rd

	////////////////////////////////////////////////////////////////////////
	// Link side, rising test clock: capture, shift and crossing.

	dbc_tap_fsm u_tap (
		.i_tck      (i_tck),
		.i_tck_rstn (pos.rst_s2),
		.i_tms      (i_tms),
		.o_state    (tap_state)
	);

	always_comb begin
		next_pos = pos;
		next_pos.rst_s1 = i_rstn;
		next_pos.rst_s2 = pos.rst_s1;
		next_pos.tog_s1 = core.tx_tog;
		next_pos.tog_s2 = pos.tog_s1;
		if (pos.tog_s2 != pos.tog_seen) begin
			next_pos.tog_seen = pos.tog_s2;
			next_pos.tx_copy = core.tx_word;
		end
		case (tap_state)
			dbc_pkg::st_cap_ir: begin
				next_pos.ir_shift = `DBC_IR_CAPTURE;
			end
			dbc_pkg::st_sh_ir: begin
				next_pos.ir_shift = {i_tdi, pos.ir_shift[2:1]};
			end
			dbc_pkg::st_cap_dr: begin
				next_pos.dr_shift = neg.reload;
				next_pos.prog_shift = 3'h0;
				next_pos.bypass = 1'b0;
			end
			dbc_pkg::st_sh_dr: begin
				case (neg.path)
					dbc_pkg::path_debug: begin
						next_pos.dr_shift =
							dbc_pkg::dbc_word_t'({i_tdi, pos.dr_shift[9:1]});
					end
					dbc_pkg::path_prog: begin
						next_pos.prog_shift = {i_tdi, pos.prog_shift[2:1]};
					end
					default: begin
						next_pos.bypass = i_tdi;
					end
				endcase
			end
			default: ;
		endcase
		if (!pos.rst_s2) begin
			next_pos.ir_shift = `DBC_IR_BYPASS;
			next_pos.dr_shift = dbc_pkg::dbc_word_t'(10'h000);
			next_pos.prog_shift = 3'h0;
			next_pos.bypass = 1'b0;
			next_pos.tog_s1 = 1'b0;
			next_pos.tog_s2 = 1'b0;
			next_pos.tog_seen = 1'b0;
			next_pos.tx_copy = dbc_pkg::dbc_word_t'(10'h000);
		end
	end

	always_ff @(posedge i_tck) begin
		pos <= next_pos;
	end

	////////////////////////////////////////////////////////////////////////
	// Link side, falling test clock: instruction, update and TDO.

	always_comb begin
		next_neg = neg;
		next_neg.tdo_oe_n = 1'b1;
		case (tap_state)
			dbc_pkg::st_tlr: begin
				next_neg.ir = `DBC_IR_BYPASS;
				next_neg.path = dbc_pkg::path_bypass;
			end
			dbc_pkg::st_sh_ir: begin
				next_neg.tdo = pos.ir_shift[0];
				next_neg.tdo_oe_n = 1'b0;
			end
			dbc_pkg::st_sh_dr: begin
				next_neg.tdo_oe_n = 1'b0;
				case (neg.path)
					dbc_pkg::path_debug: next_neg.tdo = pos.dr_shift[0];
					dbc_pkg::path_prog:  next_neg.tdo = pos.prog_shift[0];
					default:             next_neg.tdo = pos.bypass;
				endcase
			end
			dbc_pkg::st_upd_ir: begin
				next_neg.ir = pos.ir_shift;
				case (pos.ir_shift)
					`DBC_IR_DEBUG: next_neg.path = dbc_pkg::path_debug;
					`DBC_IR_PROG:  next_neg.path = dbc_pkg::path_prog;
					`DBC_IR_EXTEST, `DBC_IR_SAMPLE, `DBC_IR_RSVD: ;
					default:       next_neg.path = dbc_pkg::path_bypass;
				endcase
			end
			dbc_pkg::st_upd_dr: begin
				if (neg.path == dbc_pkg::path_debug) begin
					next_neg.reload = pos.tx_copy;
					next_neg.rx_byte = pos.dr_shift.data;
					next_neg.rx_tog = ~neg.rx_tog;
				end
			end
			default: ;
		endcase
		if (!pos.rst_s2) begin
			next_neg.ir = `DBC_IR_BYPASS;
			next_neg.path = dbc_pkg::path_bypass;
			next_neg.reload = dbc_pkg::dbc_word_t'(10'h000);
			next_neg.rx_byte = `DBC_CMD_NOP;
			next_neg.rx_tog = 1'b0;
			next_neg.tdo = 1'b1;
			next_neg.tdo_oe_n = 1'b1;
		end
	end

	always_ff @(negedge i_tck) begin
		neg <= next_neg;
	end

	////////////////////////////////////////////////////////////////////////
	// Core side: command engine and debug registers.

	assign rx_evt  = core.rx_s2 != core.rx_seen;
	assign isp_on  = i_program_enable_bit &&
		(i_program_source_select == `DBC_SRC_ISP);
	assign bg_cmd  = rx_evt && !isp_on && !core.debug_mode;
	assign rx_byte = neg.rx_byte;
	assign cmd_len = dbc_len(rx_byte);
	assign rd_word = dbc_rd(core, rx_byte[3:0]);
	assign wr_word = {rx_byte, core.hold};

	always_comb begin
		next_core = core;
		next_core.rx_s1 = neg.rx_tog;
		next_core.rx_s2 = core.rx_s1;
		next_core.fwd_valid = 1'b0;
		if (rx_evt) begin
			next_core.rx_seen = core.rx_s2;
			next_core.buffer = rx_byte;
		end
		if (rx_evt && (isp_on || core.debug_mode)) begin
			next_core.fwd_byte = rx_byte;
			next_core.fwd_valid = 1'b1;
		end
		if (bg_cmd) begin
			case (core.eng)
				dbc_pkg::eng_cmd: begin
					next_core.target = rx_byte[3:0];
					next_core.cnt = cmd_len;
					if (rx_byte == `DBC_CMD_DEBUG) begin
						next_core.debug_req = 1'b1;
					end else if (cmd_len != 2'h0 &&
							!rx_byte[`DBC_CMD_WR_BIT]) begin
						next_core.eng = dbc_pkg::eng_read;
						next_core.buffer = rd_word[7:0];
						next_core.hold = rd_word[15:8];
						if (rx_byte[3:0] == `DBC_IDX_FLAG) begin
							next_core.flag[`DBC_FLAG_BP] = 1'b0;
						end
					end else if (cmd_len != 2'h0) begin
						next_core.eng = dbc_pkg::eng_write;
					end
					// Any other byte falls through untouched.
				end
				dbc_pkg::eng_read: begin
					if (core.cnt == 2'h2) begin
						next_core.buffer = core.hold;
					end
					next_core.cnt = core.cnt - 2'h1;
					if (core.cnt == 2'h1) begin
						next_core.eng = dbc_pkg::eng_cmd;
					end
				end
				dbc_pkg::eng_write: begin
					next_core.hold = rx_byte;
					next_core.cnt = core.cnt - 2'h1;
					if (core.cnt == 2'h1) begin
						next_core.eng = dbc_pkg::eng_cmd;
						case (core.target)
							`DBC_IDX_CTRL: next_core.ctrl = rx_byte;
							`DBC_IDX_ADDR: next_core.addr = wr_word;
							`DBC_IDX_DATA: next_core.data = wr_word;
							default: ;
						endcase
						for (int i = 0; i < `DBC_BP_NUM; i++) begin
							if (core.target == 4'(i + `DBC_IDX_BRK0)) begin
								next_core.bp[i] = wr_word;
							end
						end
					end
				end
				default: next_core.eng = dbc_pkg::eng_cmd;
			endcase
		end
		if (i_bp_match) begin
			next_core.flag[`DBC_FLAG_BP] = 1'b1;
		end
		if (core.debug_req && i_instr_done) begin
			next_core.debug_req = 1'b0;
			next_core.debug_mode = 1'b1;
			next_core.halt = 1'b1;
		end
		if (core.debug_mode && i_debug_exit) begin
			next_core.debug_mode = 1'b0;
			next_core.halt = 1'b0;
			next_core.eng = dbc_pkg::eng_cmd;
		end
		next_core.tx_word.data = next_core.buffer;
		next_core.tx_word.status = next_core.debug_mode ?
			`DBC_STAT_DBG : `DBC_STAT_BG;
		if (next_core.tx_word != core.tx_word) begin
			next_core.tx_tog = ~core.tx_tog;
		end
		if (!i_rstn) begin
			next_core = '0;
			next_core.bp = {`DBC_BP_NUM{`DBC_BP_RESET}};
			next_core.addr = `DBC_REG_RESET;
			next_core.data = `DBC_REG_RESET;
			next_core.ctrl = `DBC_CTRL_RESET;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		core <= next_core;
	end

	assign o_tdo                  = neg.tdo;
	assign o_tdo_oe_n             = neg.tdo_oe_n;
	assign o_debug_mode           = core.debug_mode;
	assign o_cpu_halt             = core.halt;
	assign o_debug_control_reg    = core.ctrl;
	assign o_debug_flag_reg       = core.flag;
	assign o_debug_address_reg    = core.addr;
	assign o_debug_data_reg       = core.data;
	assign o_breakpoint_regs      = core.bp;
	assign o_debug_holding_buffer = core.buffer;
	assign o_rx_byte              = core.fwd_byte;
	assign o_rx_valid             = core.fwd_valid;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_lsb_first;
		@(posedge i_tck) disable iff (!pos.rst_s2)
		tap_state == dbc_pkg::st_sh_dr && neg.path == dbc_pkg::path_debug |=>
			pos.dr_shift == {$past(i_tdi), $past(pos.dr_shift[9:1])};
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("bad shift");

	property p_path_debug;
		@(negedge i_tck) disable iff (!pos.rst_s2)
		tap_state == dbc_pkg::st_upd_ir && pos.ir_shift == `DBC_IR_DEBUG |=>
			neg.path == dbc_pkg::path_debug;
	endproperty
	a_path_debug: assert property (p_path_debug) else $error("no path");

	property p_ir_hold;
		@(negedge i_tck) disable iff (!pos.rst_s2)
		tap_state != dbc_pkg::st_upd_ir && tap_state != dbc_pkg::st_tlr |=>
			$stable(neg.ir);
	endproperty
	a_ir_hold: assert property (p_ir_hold) else $error("ir moved");

	property p_tlr_bypass;
		@(negedge i_tck) disable iff (!pos.rst_s2)
		tap_state == dbc_pkg::st_tlr |=> neg.ir == `DBC_IR_BYPASS;
	endproperty
	a_tlr_bypass: assert property (p_tlr_bypass) else $error("no bypass");

	property p_update;
		@(negedge i_tck) disable iff (!pos.rst_s2)
		tap_state == dbc_pkg::st_upd_dr && neg.path == dbc_pkg::path_debug |=>
			neg.reload == $past(pos.tx_copy) &&
			neg.rx_byte == $past(pos.dr_shift.data);
	endproperty
	a_update: assert property (p_update) else $error("bad update");

	property p_bg_status;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		!core.debug_mode |-> core.tx_word.status == `DBC_STAT_BG;
	endproperty
	a_bg_status: assert property (p_bg_status) else $error("bad status");

	property p_nop_keep;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		bg_cmd && core.eng == dbc_pkg::eng_cmd && cmd_len == 2'h0 &&
			rx_byte != `DBC_CMD_DEBUG |=>
			$stable(core.ctrl) && $stable(core.addr) && $stable(core.data) &&
			$stable(core.bp) && !$rose(core.debug_req) &&
			core.eng == dbc_pkg::eng_cmd;
	endproperty
	a_nop_keep: assert property (p_nop_keep) else $error("nop acted");

	property p_isp_first;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		rx_evt && isp_on |=> o_rx_valid && core.eng == $past(core.eng);
	endproperty
	a_isp_first: assert property (p_isp_first) else $error("isp lost");

	property p_read_lsb;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		bg_cmd && core.eng == dbc_pkg::eng_cmd &&
			rx_byte == `DBC_CMD_RD_ADDR |=>
			core.buffer == core.addr[7:0] && core.cnt == 2'h2;
	endproperty
	a_read_lsb: assert property (p_read_lsb) else $error("bad read");

	property p_write_end;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		bg_cmd && core.eng == dbc_pkg::eng_write && core.cnt == 2'h1 &&
			core.target == `DBC_IDX_ADDR |=>
			core.addr == {core.buffer, $past(core.hold)};
	endproperty
	a_write_end: assert property (p_write_end) else $error("bad write");

	property p_halt;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		core.debug_req && i_instr_done |=> o_cpu_halt && o_debug_mode;
	endproperty
	a_halt: assert property (p_halt) else $error("no halt");

	property p_no_halt_bg;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		!core.debug_mode && !core.debug_req |=> !o_cpu_halt;
	endproperty
	a_no_halt_bg: assert property (p_no_halt_bg) else $error("stalled");

	property p_bp_flag;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		i_bp_match |=> core.flag[`DBC_FLAG_BP];
	endproperty
	a_bp_flag: assert property (p_bp_flag) else $error("flag lost");

endmodule : dbc_debug_channel

// ### sim/dbc_host_model.sv
`timescale 1ns/10ps

// Host side of the link: the clock runs only inside frames.
module dbc_host_model (
	output logic      o_tck,
	output logic      o_tms,
	output logic      o_tdi,
	input  wire logic i_tdo
);

	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b1;
	end

	// One link clock period; TDO is taken at the rising edge.
	task tick(input logic tms, input logic tdi, output logic tdo);
		o_tms = tms;
		o_tdi = tdi;
		#62.5 o_tck = 1'b1;
		tdo = i_tdo;
		#62.5 o_tck = 1'b0;
	endtask : tick

	// Five ticks with mode select high, then park in run-test-idle.
	task reset_tap;
		logic b;
		repeat (5) tick(1'b1, 1'b1, b);
		tick(1'b0, 1'b1, b);
	endtask : reset_tap

	// Instruction or data scan from run-test-idle back to it.
	task scan(input logic ir, input logic [9:0] din, input int n,
			output logic [9:0] dout);
		logic b;
		dout = 10'h3ff;
		tick(1'b1, 1'b1, b);
		if (ir) begin
			tick(1'b1, 1'b1, b);
		end
		tick(1'b0, 1'b1, b);
		tick(1'b0, 1'b1, b);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], b);
			dout[i] = b;
		end
		tick(1'b1, 1'b1, b);
		tick(1'b0, 1'b1, b);
		// Released lines float to their pull-up level.
		o_tms = 1'b1;
		o_tdi = 1'b1;
	endtask : scan

endmodule : dbc_host_model

// ### sim/dbc_debug_channel_bench.sv
`timescale 1ns/10ps

module dbc_debug_channel_bench;

	logic              i_ref_clk;
	logic              i_rstn;
	logic              tck, tms, tdi, tdo, oe_n, pe, dmode, halt, rxv;
	logic [1:0]        pss;
	logic [2:0]        evt;
	logic [7:0]        ctrl, flag, hbuf, rxb, rx_last;
	logic [15:0]       addr, data;
	logic [9:0]        w;
	dbc_pkg::dbc_bp_t  bp;
	int                num_errors, checks_done, cycles;

	dbc_debug_channel i_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
		.i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
		.o_tdo_oe_n(oe_n), .i_program_enable_bit(pe),
		.i_program_source_select(pss), .i_bp_match(evt[0]),
		.i_instr_done(evt[1]), .i_debug_exit(evt[2]),
		.o_debug_mode(dmode), .o_cpu_halt(halt),
		.o_debug_control_reg(ctrl), .o_debug_flag_reg(flag),
		.o_debug_address_reg(addr), .o_debug_data_reg(data),
		.o_breakpoint_regs(bp), .o_debug_holding_buffer(hbuf),
		.o_rx_byte(rxb), .o_rx_valid(rxv));

	dbc_host_model i_host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
		.i_tdo(tdo));

	always #4 i_ref_clk = ~i_ref_clk;

	always @(posedge i_ref_clk) begin
		if (rxv === 1'b1) begin
			rx_last <= rxb;
		end
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////

	task complete_run;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	task chk(input logic [15:0] got, input logic [15:0] exp, input string s);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: %s got %h exp %h", $time, s, got, exp);
		end
	endtask : chk

	task wt(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask : wt

	task pulse(input logic [2:0] v);
		wt(1);
		evt = v;
		wt(1);
		evt = 3'h0;
	endtask : pulse

	// One debug word out and back, then time for the core to act.
	task tx(input logic [7:0] b);
		i_host.scan(1'b0, {2'h0, b}, 10, w);
		wt(16);
	endtask : tx

	////////////////////////////////////////////////////////////////////////

	initial begin
		i_ref_clk = 1'b0;
		i_rstn = 1'b0;
		pe = 1'b0;
		pss = 2'h3;
		evt = 3'h0;
		cycles = 0;
		num_errors = 0;
		checks_done = 0;
		#3.3;
		i_host.reset_tap();
		wt(4);
		i_rstn = 1'b1;
		// The link side leaves reset only after two more test clock edges.
		i_host.reset_tap();
		wt(4);
		chk(ctrl, 16'h0000, "ctrl reset");
		chk(addr, 16'h0000, "addr reset");
		chk(data, 16'h0000, "data reset");
		chk(oe_n, 16'h0001, "tdo idle");
		for (int i = 0; i < 6; i++) begin
			chk(bp[i], 16'hffff, "bp reset");
		end
		$display("test reset done");
		i_host.scan(1'b1, 10'h002, 3, w);
		tx(8'h00);
		chk(w, 16'h0000, "nop word");
		tx(8'h11);
		tx(8'ha5);
		chk(ctrl, 16'h00a5, "ctrl write");
		tx(8'h13);
		tx(8'h34);
		tx(8'h12);
		chk(addr, 16'h1234, "addr write");
		tx(8'h14);
		tx(8'hcd);
		tx(8'hab);
		chk(data, 16'habcd, "data write");
		tx(8'h03);
		chk(hbuf, 16'h0034, "buffer low");
		tx(8'h00);
		tx(8'h00);
		chk(w[7:0], 16'h0034, "addr low");
		tx(8'h00);
		chk(w[7:0], 16'h0012, "addr high");
		tx(8'h01);
		tx(8'h00);
		tx(8'h00);
		chk(w[7:0], 16'h00a5, "ctrl read");
		for (int i = 0; i < 6; i++) begin
			tx(8'h15 + 8'(i));
			tx(8'(i));
			tx(8'ha0 + 8'(i));
			chk(bp[i], {8'ha0 + 8'(i), 8'(i)}, "bp write");
			tx(8'h05 + 8'(i));
			tx(8'h00);
			tx(8'h00);
			chk(w[7:0], 16'(i), "bp low");
		end
		$display("test access done");
		tx(8'h55);
		chk(hbuf, 16'h0055, "buffer in");
		chk({ctrl, addr[7:0]}, 16'ha534, "odd byte");
		chk({dmode, halt}, 16'h0000, "cpu free");
		pulse(3'h1);
		chk(flag, 16'h0001, "bp flag");
		tx(8'h02);
		tx(8'h00);
		tx(8'h00);
		chk(w[7:0], 16'h0001, "flag read");
		chk(flag, 16'h0000, "flag clear");
		i_host.scan(1'b1, 10'h001, 3, w);
		tx(8'h11);
		tx(8'h3c);
		chk(ctrl, 16'h003c, "path kept");
		$display("test flag done");
		wt(1);
		pe = 1'b1;
		pss = 2'h0;
		tx(8'h11);
		tx(8'h5a);
		chk(ctrl, 16'h003c, "isp ctrl");
		chk(rx_last, 16'h005a, "isp byte");
		pe = 1'b0;
		pss = 2'h3;
		$display("test isp done");
		tx(8'h1f);
		chk(dmode, 16'h0000, "wait instr");
		pulse(3'h2);
		wt(2);
		chk({dmode, halt}, 16'h0003, "halted");
		tx(8'h66);
		chk(rx_last, 16'h0066, "debug byte");
		tx(8'h00);
		chk(w[9:8], 16'h0001, "debug status");
		pulse(3'h4);
		wt(2);
		chk(dmode, 16'h0000, "exit");
		$display("test debug done");
		complete_run();
	end

endmodule : dbc_debug_channel_bench
